/* rtl/ram_error_map.svh */
`ifndef RAM_ERROR_MAP_SVH
`define RAM_ERROR_MAP_SVH

// Register byte addresses
`define RAMERR_STATUS_ADDR 12'hf80
`define RAMERR_MASK_ADDR 12'hf84
`define RAMERR_TIMEOUT_ADDR 12'hf88
`define RAMERR_IRQ_ENABLE_ADDR 12'hf8c

// Status and mask bit positions
`define RAMERR_BIT_CPL_OVF 0
`define RAMERR_BIT_EG_PKT_SOFT 1
`define RAMERR_BIT_EG_LL_SOFT 2
`define RAMERR_BIT_EG_PKT_ECC 3
`define RAMERR_BIT_EG_LL_ECC 4
`define RAMERR_BIT_IN_SOFT 5
`define RAMERR_BIT_IN_UNCOR 8

// Implemented bits and reset values
`define RAMERR_IMPL_MASK 32'h0000013f
`define RAMERR_STATUS_RESET 32'h00000000
`define RAMERR_MASK_RESET 32'h0000013f
`define RAMERR_TIMEOUT_RESET 8'h00
`define RAMERR_IRQ_ENABLE_RESET 1'h0

// Soft-error counter
`define RAMERR_SOFT_CNT_W 8

`endif

/* rtl/ram_error_pkg.sv */
`default_nettype none
package ram_error_pkg;

    // Error events reported by the datapath, one pulse each
    typedef struct packed {
        logic ingressCplOverflow;
        logic egressCplOverflow;
        logic egressPacketRamSoft;
        logic egressLinkListRamSoft;
        logic egressPacketRamEcc2;
        logic egressLinkListRamEcc2;
        logic ingressPacketRamSoft;
        logic ingressPacketRamEcc2;
    } ram_error_events_t;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : ram_error_pkg
`default_nettype wire

/* rtl/ram_error_status_bank.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ram_error_map.svh"

// Overview of operation
// - Unmasked recorded errors raise the interrupt when interrupt generation is enabled.
// - Bit 0 sets on ingress or egress completion FIFO overflow.
// - Egress packet RAM soft errors counted; count reaching 256 sets bit 1.
// - Egress link-list RAM soft errors counted; count reaching 256 sets bit 2.
// - Egress packet RAM double-bit ECC error sets bit 3.
// - Egress link-list RAM double-bit ECC error sets bit 4.
// - Ingress packet RAM correctable single-bit error sets bit 5.
// - Ingress uncorrectable ECC error sets bit 8; other bits read zero.
// - Mask bit 0 gates completion overflow interrupt; one masks, resets to one.
// - Mask bits 1-5 and 8 gate matching flags; all reset to one.
// - Timeout field bits 7:0, cleared by software write, resets to zero.
module ram_error_status_bank (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic powerOnResetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ram_error_pkg::ram_error_events_t events,
    input wire logic tagTimeoutSet,
    input wire logic [7:0] tagTimeoutValue,
    output logic irq
);

    ram_error_pkg::apb_req_t req;
    logic [31:0] status;
    logic [31:0] mask;
    logic [7:0] tagTimeout;
    logic irqEnable;
    logic [31:0] setBits;
    logic [31:0] next_status;
    logic writeStrobe;
    logic eccPktOverflow;
    logic eccLlOverflow;

    // Decodes a byte address into a mapped-register hit
    function automatic logic addrMapped(input logic [11:0] a);
        addrMapped = (a == `RAMERR_STATUS_ADDR) || (a == `RAMERR_MASK_ADDR) ||
                     (a == `RAMERR_TIMEOUT_ADDR) || (a == `RAMERR_IRQ_ENABLE_ADDR);
    endfunction

    always_comb begin
        req.psel = psel;
        req.penable = penable;
        req.pwrite = pwrite;
        req.paddr = paddr;
        req.pwdata = pwdata;
    end

    // Zero-wait slave; unmapped addresses answer with pslverr
    always_comb begin
        pready = 1'b1;
        pslverr = req.psel && req.penable && !addrMapped(req.paddr);
        writeStrobe = req.psel && req.penable && req.pwrite;
    end

    soft_error_counter #(
        .WIDTH(`RAMERR_SOFT_CNT_W)
    ) u_egress_packet_cnt (
        .mclk(mclk),
        .resetn(resetn),
        .softError(events.egressPacketRamSoft),
        .overflow(eccPktOverflow)
    );

    soft_error_counter #(
        .WIDTH(`RAMERR_SOFT_CNT_W)
    ) u_egress_link_list_cnt (
        .mclk(mclk),
        .resetn(resetn),
        .softError(events.egressLinkListRamSoft),
        .overflow(eccLlOverflow)
    );

    // Event-to-bit mapping; reserved positions never set
    always_comb begin
        setBits = '0;
        setBits[`RAMERR_BIT_CPL_OVF] = events.ingressCplOverflow ||
                                      events.egressCplOverflow;
        setBits[`RAMERR_BIT_EG_PKT_SOFT] = eccPktOverflow;
        setBits[`RAMERR_BIT_EG_LL_SOFT] = eccLlOverflow;
        setBits[`RAMERR_BIT_EG_PKT_ECC] = events.egressPacketRamEcc2;
        setBits[`RAMERR_BIT_EG_LL_ECC] = events.egressLinkListRamEcc2;
        setBits[`RAMERR_BIT_IN_SOFT] = events.ingressPacketRamSoft;
        setBits[`RAMERR_BIT_IN_UNCOR] = events.ingressPacketRamEcc2;
    end

    // Write-one-to-clear; a simultaneous event wins so nothing is lost
    always_comb begin
        next_status = status;
        if (writeStrobe && (req.paddr == `RAMERR_STATUS_ADDR)) begin
            next_status = status & ~req.pwdata;
        end
        next_status = (next_status | setBits) & `RAMERR_IMPL_MASK;
    end

    // Sticky flags: power-on reset or a write-one clears them, warm reset keeps them
    always_ff @(posedge mclk) begin
        if (!powerOnResetn) begin
            status <= `RAMERR_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Sticky mask, also held across warm reset
    always_ff @(posedge mclk) begin
        if (!powerOnResetn) begin
            mask <= `RAMERR_MASK_RESET;
        end else if (writeStrobe && (req.paddr == `RAMERR_MASK_ADDR)) begin
            mask <= req.pwdata & `RAMERR_IMPL_MASK;
        end
    end

    // Interrupt generation enable, a plain control bit
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irqEnable <= `RAMERR_IRQ_ENABLE_RESET;
        end else if (writeStrobe && (req.paddr == `RAMERR_IRQ_ENABLE_ADDR)) begin
            irqEnable <= req.pwdata[0];
        end
    end

    // Timeout field: hardware loads it, any software write clears it; load wins
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tagTimeout <= `RAMERR_TIMEOUT_RESET;
        end else if (tagTimeoutSet) begin
            tagTimeout <= tagTimeoutValue;
        end else if (writeStrobe && (req.paddr == `RAMERR_TIMEOUT_ADDR)) begin
            tagTimeout <= `RAMERR_TIMEOUT_RESET;
        end
    end

    // Level interrupt while any unmasked flag is set
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irqEnable && |(next_status & ~mask);
        end
    end

    // Read mux; registered so data comes from flops in the access phase
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (req.psel && !req.penable && !req.pwrite) begin
            unique case (req.paddr)
                `RAMERR_STATUS_ADDR: prdata <= status;
                `RAMERR_MASK_ADDR: prdata <= mask;
                `RAMERR_TIMEOUT_ADDR: prdata <= {24'h000000, tagTimeout};
                `RAMERR_IRQ_ENABLE_ADDR: prdata <= {31'h00000000, irqEnable};
                default: prdata <= '0;
            endcase
        end
    end

endmodule : ram_error_status_bank
`default_nettype wire

/* rtl/soft_error_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ram_error_map.svh"

module soft_error_counter #(
    parameter int WIDTH = `RAMERR_SOFT_CNT_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic softError,
    output logic overflow
);

    logic [WIDTH-1:0] count;

    // Wraps at full scale so the overflow pulse fires once per wrap
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            count <= '0;
        end else if (softError) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Pulse when the 2**WIDTH-th error arrives (count reaches 256)
    always_comb begin
        overflow = softError && (count == {WIDTH{1'b1}});
    end

endmodule : soft_error_counter
`default_nettype wire

/* testbench/ram_error_status_bank_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ram_error_status_bank_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire ram_error_pkg::ram_error_events_t events,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Access phase of a status read, when its word is on prdata
    sequence stRead;
        psel && !penable && !pwrite && paddr == 12'hf80 ##1 psel && penable;
    endsequence
    wire logic wr = psel && penable && pwrite;
    rsvd_zero_a: assert property (stRead |-> prdata[31:9] == 0 && prdata[7:6] == 0)
        else $error("Reserved status bits set");
    cpl_ovf_a: assert property ((events.ingressCplOverflow || events.egressCplOverflow)
        ##[1:2] stRead |-> prdata[0]) else $error("Overflow flag missing");
    pkt_ecc_a: assert property (events.egressPacketRamEcc2 ##[1:2] stRead |-> prdata[3])
        else $error("Packet RAM ECC flag missing");
    ll_ecc_a: assert property (events.egressLinkListRamEcc2 ##[1:2] stRead |-> prdata[4])
        else $error("Link-list ECC flag missing");
    in_soft_a: assert property (events.ingressPacketRamSoft ##[1:2] stRead |-> prdata[5])
        else $error("Ingress soft flag missing");
    in_uncor_a: assert property (events.ingressPacketRamEcc2 ##[1:2] stRead |-> prdata[8])
        else $error("Ingress uncorrectable flag missing");
    // A new interrupt needs a fresh event or a register write behind it
    irq_cause_a: assert property ($rose(irq) |-> $past(|events) || $past(wr) || $past(wr, 2))
        else $error("Interrupt without cause");
    irq_hold_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("Interrupt dropped without write");
endmodule // ram_error_status_bank_chk
bind ram_error_status_bank ram_error_status_bank_chk i_chk (.mclk(mclk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .events(events), .irq(irq));
`default_nettype wire

/* testbench/ram_error_status_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ram_error_status_bank_tb;
    logic mclk = 0, resetn = 0, powerOnResetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic tagTimeoutSet = 0, pready, pslverr, irq, errv;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic [7:0] tagTimeoutValue = '0;
    ram_error_pkg::ram_error_events_t events = '0;
    int errors = 0, testsRun = 0, cnt;
    int bitPos [8] = '{0, 0, 1, 2, 3, 4, 5, 8};
    always #12.5 mclk = ~mclk;
    ram_error_status_bank i_ram_error_status_bank (.mclk(mclk), .resetn(resetn),
        .powerOnResetn(powerOnResetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .tagTimeoutSet(tagTimeoutSet), .tagTimeoutValue(tagTimeoutValue),
        .irq(irq));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // Request is held until pready is seen high; starts one edge late so no signal is set twice
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        xfer(1'h0, a, 32'h0);
        chk(n, e, rdv);
    endtask
    task automatic pulse(input ram_error_pkg::ram_error_events_t v);
        @(posedge mclk);
        events <= v;
        @(posedge mclk);
        events <= '0;
    endtask
    task automatic irqIs(input logic e, input string n);
        repeat (3) @(posedge mclk);
        chk(n, {31'h0, e}, {31'h0, irq});
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, testsRun);
        if (errors == 0 && testsRun > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        powerOnResetn <= 1'h1;
        rd(12'hf80, 32'h0, "status");
        chk("slverr ok", 32'h0, {31'h0, errv});
        rd(12'hf84, 32'h13f, "mask");
        rd(12'hf88, 32'h0, "timeout");
        // Unmapped word reads zero and is flagged with an error response
        rd(12'hf90, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, errv});
        xfer(1'h1, 12'hf84, 32'hffffffff);
        rd(12'hf84, 32'h13f, "mask rsvd");
        // Egress soft-error flags need 255 silent pulses first; the rest set on the first
        for (int i = 0; i < 8; i++) begin
            cnt = (i == 2 || i == 3) ? 256 : 1;
            repeat (cnt - 1) pulse(8'h80 >> i);
            rd(12'hf80, 32'h0, "early");
            pulse(8'h80 >> i);
            rd(12'hf80, 32'h1 << bitPos[i], "set");
            xfer(1'h1, 12'hf80, 32'h0);
            rd(12'hf80, 32'h1 << bitPos[i], "kept");
            xfer(1'h1, 12'hf80, 32'h1 << bitPos[i]);
            rd(12'hf80, 32'h0, "cleared");
        end
        xfer(1'h1, 12'hf8c, 32'h1);
        rd(12'hf8c, 32'h1, "irq en");
        pulse(8'h80);
        irqIs(1'h0, "masked");
        xfer(1'h1, 12'hf84, 32'h13e);
        irqIs(1'h1, "unmasked");
        xfer(1'h1, 12'hf84, 32'h0);
        xfer(1'h1, 12'hf80, 32'h1);
        irqIs(1'h0, "irq clr");
        pulse(8'h01);
        irqIs(1'h1, "irq bit8");
        // Warm reset must not lose flags or masks
        @(posedge mclk);
        resetn <= 1'h0;
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        rd(12'hf80, 32'h100, "warm st");
        rd(12'hf84, 32'h0, "warm mask");
        irqIs(1'h0, "irq off");
        @(posedge mclk);
        tagTimeoutSet <= 1'h1;
        tagTimeoutValue <= 8'ha5;
        @(posedge mclk);
        tagTimeoutSet <= 1'h0;
        rd(12'hf88, 32'ha5, "tag");
        xfer(1'h1, 12'hf88, 32'h0);
        rd(12'hf88, 32'h0, "tag clr");
        wrap_up;
    end
    // Watchdog, well past the roughly 1260 cycles the sequence needs
    initial begin
        repeat (6000) @(posedge mclk);
        errors++;
        wrap_up;
    end
endmodule // ram_error_status_bank_tb
`default_nettype wire
